// ### rtl/lvd_top.sv
/*
  Low-voltage detector control: control/status register, comparator
  synchronisation, delayed interrupt request flag and idle wake-up, all
  reached over AXI4-Lite. Assumes an analog comparator that reports the
  supply below the selected threshold on an asynchronous level, and a
  power manager that reports SLEEP and IDLE as synchronous levels.
*/
// The AXI4-Lite register port and the register addresses were decided locally.
// Operation
// - Control register bits 7 and 6 always read as zero.
// - Bit 5 is the read-only low-voltage flag; writes to it are ignored.
// - Bit 3 enables the bandgap buffer when one, disables when zero.
// - Bits 2..0 pick one of eight thresholds, 2.0 V up to 4.0 V.
// - Flag is high while supply is below threshold, low while above.
// - In SLEEP the detector is off whatever the enable bit says.
// - Every flag transition near the threshold passes through, none latched.
// - Interrupt request flag sets only after a fixed delay after flag rise; a write to the set register also sets it at once.
// - Interrupt request flag becoming set wakes the device from IDLE.
// - Enable bit set turns the detector on; cleared turns it off.
// - Wake-up follows the flag rise regardless of the interrupt mask.

module lvd_top (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_srst,
  // AXI4-Lite write address
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  // AXI4-Lite write data
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  // AXI4-Lite write response
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  // AXI4-Lite read address
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  // AXI4-Lite read data
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  // Power state
  input  wire logic        i_sleep_mode,
  input  wire logic        i_idle_mode,
  // Analog comparator side
  input  wire logic        i_cmp_below,
  output logic             o_detector_on,
  output logic             o_bandgap_buffer_en,
  output logic [2:0]       o_threshold_select,
  // System events
  output logic             o_irq,
  output logic             o_wake_idle
);

  // ----------------------------------------------------------------------
  // Register decode, shared by the read and write paths
  // ----------------------------------------------------------------------
  function automatic lvd_pkg::lvd_reg_t decode(input logic [7:0] addr);
    if (addr == lvd_pkg::ADDR_CTRL) begin
      return lvd_pkg::LVD_REG_CTRL;
    end else if (addr == lvd_pkg::ADDR_IRQ_STAT) begin
      return lvd_pkg::LVD_REG_STAT;
    end else if (addr == lvd_pkg::ADDR_IRQ_MASK) begin
      return lvd_pkg::LVD_REG_MASK;
    end else if (addr == lvd_pkg::ADDR_IRQ_SET) begin
      return lvd_pkg::LVD_REG_SET;
    end else if (addr == lvd_pkg::ADDR_THRESH_MV) begin
      return lvd_pkg::LVD_REG_THR;
    end else begin
      return lvd_pkg::LVD_REG_NONE;
    end
  endfunction : decode

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic                          detector_enable_bit_q;
  logic                          bandgap_buffer_enable_q;
  logic [lvd_pkg::SEL_W-1:0]     threshold_select_q;
  logic                          low_volt_out_flag_q;
  logic                          flag_prev_q;
  logic [lvd_pkg::IRQ_W-1:0]     irq_stat_q;
  logic [lvd_pkg::IRQ_W-1:0]     irq_mask_q;
  logic                          irq_det_prev_q;
  logic                          aw_held_q;
  logic                          w_held_q;
  logic [7:0]                    awaddr_q;
  logic [7:0]                    wbyte_q;
  logic                          wlane_q;
  logic                          cmp_sync;
  logic                          det_active;
  logic                          aw_hs;
  logic                          w_hs;
  logic                          wr_go;
  logic                          ar_hs;
  lvd_pkg::lvd_reg_t             wr_reg;
  lvd_pkg::lvd_reg_t             rd_reg;
  logic [lvd_pkg::IRQ_W-1:0]     irq_set_ev;
  logic [lvd_pkg::IRQ_W-1:0]     irq_clr_wr;
  logic [lvd_pkg::IRQ_W-1:0]     irq_set_wr;
  logic [lvd_pkg::CTRL_W-1:0]    ctrl_view;
  logic [31:0]                   rd_word;

  lvd_dly_if dly_if ();

  // ----------------------------------------------------------------------
  // Comparator synchroniser
  // ----------------------------------------------------------------------
  lvd_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_async   (i_cmp_below),
    .o_sync    (cmp_sync)
  );

  // Detector is live only when enabled and the device is not asleep
  assign det_active = detector_enable_bit_q && !i_sleep_mode;

  // ----------------------------------------------------------------------
  // Analog-facing outputs, all from flip-flops
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_detector_on       <= 1'b0;
      o_bandgap_buffer_en <= 1'b0;
      o_threshold_select  <= '0;
    end else begin
      o_detector_on       <= det_active;
      o_bandgap_buffer_en <= bandgap_buffer_enable_q;
      o_threshold_select  <= threshold_select_q;
    end
  end

  // ----------------------------------------------------------------------
  // Low-voltage flag: follows the synchronised comparator, no latching
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      low_volt_out_flag_q <= 1'b0;
      flag_prev_q         <= 1'b0;
    end else begin
      // Off detector reports no low voltage; an unpowered
      // comparator output means nothing
      low_volt_out_flag_q <= det_active && cmp_sync;
      flag_prev_q         <= low_volt_out_flag_q;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt delay timer
  // ----------------------------------------------------------------------
  assign dly_if.flag_level = low_volt_out_flag_q;

  lvd_irq_delay u_dly (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .dly       (dly_if.timer)
  );

  // ----------------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------------
  assign aw_hs  = i_awvalid && o_awready;
  assign w_hs   = i_wvalid && o_wready;
  assign wr_go  = aw_held_q && w_held_q && !o_bvalid;
  assign ar_hs  = i_arvalid && o_arready;
  assign wr_reg = decode(awaddr_q);
  assign rd_reg = decode(i_araddr);

  // Write address channel
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_awready <= 1'b1;
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (aw_hs) begin
      o_awready <= 1'b0;
      aw_held_q <= 1'b1;
      awaddr_q  <= i_awaddr;
    end else if (o_bvalid && i_bready) begin
      o_awready <= 1'b1;
      aw_held_q <= 1'b0;
    end
  end

  // Write data channel; only byte lane 0 counts
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_wready <= 1'b1;
      w_held_q <= 1'b0;
      wbyte_q  <= '0;
      wlane_q  <= 1'b0;
    end else if (w_hs) begin
      o_wready <= 1'b0;
      w_held_q <= 1'b1;
      wbyte_q  <= i_wdata[7:0];
      wlane_q  <= i_wstrb[0];
    end else if (o_bvalid && i_bready) begin
      o_wready <= 1'b1;
      w_held_q <= 1'b0;
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= lvd_pkg::RESP_OKAY;
    end else if (wr_go) begin
      o_bvalid <= 1'b1;
      o_bresp  <= (wr_reg == lvd_pkg::LVD_REG_NONE) ? lvd_pkg::RESP_SLVERR
                                                    : lvd_pkg::RESP_OKAY;
    end else if (o_bvalid && i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Control register writes; the flag bit has no storage behind it
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      detector_enable_bit_q   <= lvd_pkg::CTRL_RW_RST[lvd_pkg::CTRL_EN_BIT];
      bandgap_buffer_enable_q <= lvd_pkg::CTRL_RW_RST[lvd_pkg::CTRL_BG_BIT];
      threshold_select_q      <= lvd_pkg::CTRL_RW_RST[lvd_pkg::SEL_W-1:0];
    end else if (wr_go && wlane_q && wr_reg == lvd_pkg::LVD_REG_CTRL) begin
      detector_enable_bit_q   <= wbyte_q[lvd_pkg::CTRL_EN_BIT];
      bandgap_buffer_enable_q <= wbyte_q[lvd_pkg::CTRL_BG_BIT];
      threshold_select_q      <= wbyte_q[lvd_pkg::CTRL_SEL_LSB +: lvd_pkg::SEL_W];
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status: hardware and software set, write-one clears
  // ----------------------------------------------------------------------
  always_comb begin
    irq_set_ev = '0;
    irq_set_ev[lvd_pkg::IRQ_DET_BIT] = dly_if.elapsed;
    irq_set_ev[lvd_pkg::IRQ_CLR_BIT] = flag_prev_q && !low_volt_out_flag_q;
  end

  assign irq_clr_wr = (wr_go && wlane_q && wr_reg == lvd_pkg::LVD_REG_STAT)
                      ? wbyte_q[lvd_pkg::IRQ_W-1:0] : '0;
  // Pre-setting the request flag masks the wake-up edge
  assign irq_set_wr = (wr_go && wlane_q && wr_reg == lvd_pkg::LVD_REG_SET)
                      ? wbyte_q[lvd_pkg::IRQ_W-1:0] : '0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      irq_stat_q <= lvd_pkg::IRQ_RST;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr_wr) | irq_set_ev | irq_set_wr;
    end
  end

  // Mask register
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      irq_mask_q <= lvd_pkg::IRQ_RST;
    end else if (wr_go && wlane_q && wr_reg == lvd_pkg::LVD_REG_MASK) begin
      irq_mask_q <= wbyte_q[lvd_pkg::IRQ_W-1:0];
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------------
  // Idle wake-up: a rising request flag wakes, mask plays no part
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      irq_det_prev_q <= 1'b0;
      o_wake_idle    <= 1'b0;
    end else begin
      irq_det_prev_q <= irq_stat_q[lvd_pkg::IRQ_DET_BIT];
      // A flag already high gives no edge, so no wake-up
      o_wake_idle    <= i_idle_mode && irq_stat_q[lvd_pkg::IRQ_DET_BIT]
                        && !irq_det_prev_q;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb begin
    ctrl_view                          = '0;
    ctrl_view[lvd_pkg::CTRL_FLAG_BIT]  = low_volt_out_flag_q;
    ctrl_view[lvd_pkg::CTRL_EN_BIT]    = detector_enable_bit_q;
    ctrl_view[lvd_pkg::CTRL_BG_BIT]    = bandgap_buffer_enable_q;
    ctrl_view[lvd_pkg::CTRL_SEL_LSB +: lvd_pkg::SEL_W] = threshold_select_q;
  end

  always_comb begin
    rd_word = '0;
    case (rd_reg)
      lvd_pkg::LVD_REG_CTRL: begin
        rd_word[lvd_pkg::CTRL_W-1:0] = ctrl_view;
      end
      lvd_pkg::LVD_REG_STAT: begin
        rd_word[lvd_pkg::IRQ_W-1:0] = irq_stat_q;
      end
      lvd_pkg::LVD_REG_MASK: begin
        rd_word[lvd_pkg::IRQ_W-1:0] = irq_mask_q;
      end
      lvd_pkg::LVD_REG_THR: begin
        rd_word[15:0] = lvd_pkg::THRESH_MV[threshold_select_q];
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  // Read channel; answer one cycle after the address is taken
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= lvd_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= rd_word;
      o_rresp   <= (rd_reg == lvd_pkg::LVD_REG_NONE) ? lvd_pkg::RESP_SLVERR
                                                     : lvd_pkg::RESP_OKAY;
    end else if (o_rvalid && i_rready) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
    end
  end

endmodule : lvd_top

// ### rtl/lvd_pkg.sv
/*
  Constants of the low-voltage detector block: register map, fields,
  reset values, timing and the threshold table.
  Assumes a single 250 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package lvd_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS     = 4000;
  localparam int unsigned IRQ_DELAY_NS      = 1000;
  // Least time: round up to whole cycles, never below one
  localparam int unsigned IRQ_DELAY_CYC_RAW =
    (IRQ_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned IRQ_DELAY_CYC     = (IRQ_DELAY_CYC_RAW < 1) ? 1 : IRQ_DELAY_CYC_RAW;
  localparam int unsigned DLY_W             = 12;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_SET   = 8'h0C;
  localparam logic [7:0] ADDR_THRESH_MV = 8'h10;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int unsigned CTRL_FLAG_BIT = 5;
  localparam int unsigned CTRL_EN_BIT   = 4;
  localparam int unsigned CTRL_BG_BIT   = 3;
  localparam int unsigned CTRL_SEL_LSB  = 0;
  localparam int unsigned SEL_W         = 3;
  localparam int unsigned CTRL_W        = 8;
  localparam logic [4:0]  CTRL_RW_RST   = 5'h00;

  // ----------------------------------------------------------------------
  // Interrupt status / mask fields
  // ----------------------------------------------------------------------
  localparam int unsigned IRQ_W         = 2;
  localparam int unsigned IRQ_DET_BIT   = 0;
  localparam int unsigned IRQ_CLR_BIT   = 1;
  localparam logic [1:0]  IRQ_RST       = 2'h0;

  // ----------------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Threshold in millivolts for each select code
  localparam logic [15:0] THRESH_MV [8] = '{16'h07D0, 16'h0898, 16'h0960, 16'h0A8C,
                                            16'h0BB8, 16'h0CE4, 16'h0E10, 16'h0FA0};

  typedef enum logic [2:0] {
    LVD_REG_CTRL, LVD_REG_STAT, LVD_REG_MASK, LVD_REG_SET, LVD_REG_THR, LVD_REG_NONE
  } lvd_reg_t;

endpackage : lvd_pkg

// ### rtl/lvd_dly_if.sv
/*
  Carrier between the main block and its interrupt delay timer.
  Assumes both ends run on the same system clock.
*/
interface lvd_dly_if;
  logic flag_level;   // Synchronised low-voltage flag, gated by enable
  logic elapsed;      // One-cycle pulse when the delay has run out

  modport ctrl  (output flag_level, input  elapsed);
  modport timer (input  flag_level, output elapsed);
endinterface : lvd_dly_if

// ### rtl/lvd_sync.sv
/*
  Two-flop synchroniser for the asynchronous comparator output.
  Assumes the input may change at any time relative to the clock.
*/
module lvd_sync (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_srst,
  // Data
  input  wire logic i_async,
  output logic      o_sync
);

  logic meta_q;

  // ----------------------------------------------------------------------
  // Two stages; the first is read by the second only
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      meta_q <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule : lvd_sync

// ### rtl/lvd_irq_delay.sv
/*
  Delay from the low-voltage flag rising to the interrupt request.
  Assumes a synchronised flag level at its input.
*/
module lvd_irq_delay (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_srst,
  // Flag in, elapsed pulse out
  lvd_dly_if.timer  dly
);

  logic [lvd_pkg::DLY_W-1:0] cnt_q;
  logic                      done_q;
  logic                      pulse_q;

  assign dly.elapsed = pulse_q;

  // ----------------------------------------------------------------------
  // Count while the flag stays high; a drop restarts the wait
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || !dly.flag_level) begin
      cnt_q   <= '0;
      done_q  <= 1'b0;
      pulse_q <= 1'b0;
    end else if (!done_q) begin
      cnt_q   <= cnt_q + 1'b1;
      // One pulse per low-voltage episode
      if (cnt_q == lvd_pkg::DLY_W'(lvd_pkg::IRQ_DELAY_CYC - 1)) begin
        done_q  <= 1'b1;
        pulse_q <= 1'b1;
      end
    end else begin
      pulse_q <= 1'b0;
    end
  end

endmodule : lvd_irq_delay

// ### testbench/lvd_cmp_model.sv
/*
  Model of the analog supply comparator.
  Assumes a supply in millivolts; output is asynchronous.
*/
module lvd_cmp_model (
  // Clock
  input  wire logic        i_ref_clk,
  // Control from the detector logic
  input  wire logic        i_on,
  input  wire logic [2:0]  i_sel,
  input  wire logic [15:0] i_supply_mv,
  // Comparator result
  output logic             o_below
);
  logic toggle_q = 1'b0;

  // Unpowered output never sits still
  always_ff @(posedge i_ref_clk) begin
    toggle_q <= ~toggle_q;
  end

  // Supply against the selected threshold
  assign o_below = i_on ? (i_supply_mv < lvd_pkg::THRESH_MV[i_sel]) : toggle_q;
endmodule : lvd_cmp_model

// ### testbench/lvd_checker.sv
/*
  Checker bound to the ports of lvd_top.
  Assumes one clock and a synchronous active-high reset.
*/
module lvd_checker (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_srst,
  // Bus
  input  wire logic        i_arvalid,
  input  wire logic        o_arready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        o_bvalid,
  input  wire logic        o_rvalid,
  input  wire logic [31:0] o_rdata,
  // Detector and power
  input  wire logic        i_sleep_mode,
  input  wire logic        i_idle_mode,
  input  wire logic        i_cmp_below,
  input  wire logic        o_detector_on,
  input  wire logic        o_bandgap_buffer_en,
  input  wire logic [2:0]  o_threshold_select,
  input  wire logic        o_wake_idle
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  logic [9:0] below_q, above_q, off_q;
  logic       rd_ctrl_q;

  // Saturating run lengths
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      below_q <= '0;
      above_q <= '0;
      off_q   <= '0;
    end else begin
      below_q <= (o_detector_on && i_cmp_below) ? below_q + 10'(below_q != 10'h3FF) : '0;
      above_q <= (o_detector_on && !i_cmp_below) ? above_q + 10'(above_q != 10'h3FF) : '0;
      off_q   <= !o_detector_on ? off_q + 10'(off_q != 10'h3FF) : '0;
    end
  end

  // Read in flight targets the control register
  always_ff @(posedge i_ref_clk) begin
    if (i_arvalid && o_arready) begin
      rd_ctrl_q <= (i_araddr == lvd_pkg::ADDR_CTRL);
    end
  end

  sequence s_ctrl_rd;
    o_rvalid && rd_ctrl_q;
  endsequence

  property p_hi_zero;     s_ctrl_rd |-> o_rdata[31:6] == 26'h0; endproperty
  property p_flag_low;    s_ctrl_rd ##0 (above_q >= 10'd8) |-> !o_rdata[5]; endproperty
  property p_flag_high;   s_ctrl_rd ##0 (below_q >= 10'd8) |-> o_rdata[5]; endproperty
  property p_flag_off;    s_ctrl_rd ##0 (off_q >= 10'd8) |-> !o_rdata[5]; endproperty
  property p_sleep_off;   i_sleep_mode |=> !o_detector_on; endproperty
  property p_cfg_write;
    $changed({o_bandgap_buffer_en, o_threshold_select}) |->
      o_bvalid || $past(o_bvalid) || $past(o_bvalid, 2);
  endproperty
  property p_wake_delay;  o_wake_idle |-> below_q >= 10'd250; endproperty
  property p_wake_pulse;  o_wake_idle |=> !o_wake_idle; endproperty
  property p_wake_idle;
    o_wake_idle |-> i_idle_mode || $past(i_idle_mode) || $past(i_idle_mode, 2);
  endproperty
  property p_rd_answer;   i_arvalid && o_arready |=> o_rvalid && !o_arready; endproperty

  a_hi_zero:    assert property (p_hi_zero)    else $error("ctrl upper bits not zero");
  a_flag_low:   assert property (p_flag_low)   else $error("flag set above threshold");
  a_flag_high:  assert property (p_flag_high)  else $error("flag clear below level");
  a_flag_off:   assert property (p_flag_off)   else $error("flag set while off");
  a_sleep_off:  assert property (p_sleep_off)  else $error("detector on in sleep");
  a_cfg_write:  assert property (p_cfg_write)  else $error("config moved unwritten");
  a_wake_delay: assert property (p_wake_delay) else $error("wake before delay");
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake not a pulse");
  a_wake_idle:  assert property (p_wake_idle)  else $error("wake outside idle");
  a_rd_answer:  assert property (p_rd_answer)  else $error("read answer late");
endmodule : lvd_checker

bind lvd_top lvd_checker i_chk (.i_ref_clk, .i_srst, .i_arvalid, .o_arready, .i_araddr,
  .o_bvalid, .o_rvalid, .o_rdata, .i_sleep_mode, .i_idle_mode, .i_cmp_below, .o_detector_on,
  .o_bandgap_buffer_en, .o_threshold_select, .o_wake_idle);

// ### testbench/lvd_top_bench.sv
/*
  Bench for lvd_top: table rows, then hand-written cases.
  Assumes the comparator model and checker.
*/
module lvd_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_CT = lvd_pkg::ADDR_CTRL;
  localparam logic [7:0] A_ST = lvd_pkg::ADDR_IRQ_STAT;
  localparam logic [1:0] OK = lvd_pkg::RESP_OKAY;
  localparam logic [1:0] ER = lvd_pkg::RESP_SLVERR;
  // Rows: select code, expected flag (supply just below when one)
  localparam logic [7:0] ROWS [8] = '{8'h01, 8'h10, 8'h21, 8'h30, 8'h41, 8'h50, 8'h61, 8'h70};
  logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0;
  logic        rre = 1'b0, slp = 1'b0, idl = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd, got;
  logic [15:0] mv = 16'h0FFF;
  logic [1:0]  br, rr, resp;
  logic [2:0]  sel, s;
  logic        awr, wrr, bv, arr, rv, cmp, on, bg, irq, wake, f;
  int          n_fail = 0, num_checks = 0, n_wake = 0, w0, n;

  lvd_top i_dut (.i_ref_clk(clk), .i_srst(rst), .i_awvalid(awv), .o_awready(awr),
    .i_awaddr(awa), .i_wvalid(wv), .o_wready(wrr), .i_wdata(wd), .i_wstrb(4'hF),
    .o_bvalid(bv), .i_bready(bre), .o_bresp(br), .i_arvalid(arv), .o_arready(arr),
    .i_araddr(ara), .o_rvalid(rv), .i_rready(rre), .o_rdata(rd), .o_rresp(rr),
    .i_sleep_mode(slp), .i_idle_mode(idl), .i_cmp_below(cmp), .o_detector_on(on),
    .o_bandgap_buffer_en(bg), .o_threshold_select(sel), .o_irq(irq), .o_wake_idle(wake));
  lvd_cmp_model i_cmp (.i_ref_clk(clk), .i_on(on), .i_sel(sel), .i_supply_mv(mv),
    .o_below(cmp));

  // ----------------------------------------------------------------------
  // Clock, wake counter, watchdog
  // ----------------------------------------------------------------------
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (wake === 1'b1) n_wake <= n_wake + 1;
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    results();
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] act);
    num_checks++;
    if (act !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, act);
    end
  endtask : chk

  // Write: AW and W offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit fin = 0;
    resp = 2'bxx;
    @(posedge clk);
    {awv, wv, bre} <= 3'h7;
    awa <= a;
    wd <= d;
    while (!fin) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrr) wv <= 1'b0;
      if (bre && bv) begin
        resp = br;
        bre <= 1'b0;
        fin = 1;
      end
    end
    chk($sformatf("bresp %h", a), er, resp);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit fin = 0;
    resp = 2'bxx;
    got = 'x;
    @(posedge clk);
    {arv, rre} <= 2'h3;
    ara <= a;
    while (!fin) begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rre && rv) begin
        {resp, got} = {rr, rd};
        rre <= 1'b0;
        fin = 1;
      end
    end
    chk($sformatf("reg %h", a), ed, got);
    chk($sformatf("rresp %h", a), er, resp);
  endtask : rdc

  task automatic results;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc(A_CT, 32'h0, OK);
    rdc(A_ST, 32'h0, OK);
    chk("irq", 32'h0, irq);
    rdc(8'h14, 32'h0, ER);
    wr(8'h14, 32'hFF, ER);
    $display("test reset done");
    // Bits 7:5 written high must not stick
    for (int i = 0; i < 8; i++) begin
      {s, f} = {ROWS[i][6:4], ROWS[i][0]};
      @(posedge clk) mv <= f ? lvd_pkg::THRESH_MV[s] - 16'h1 : lvd_pkg::THRESH_MV[s] + 16'h1;
      wr(A_CT, 32'hF8 | 32'(s), OK);
      repeat (10) @(posedge clk); // Settling before trusting the flag
      rdc(A_CT, 32'h18 | 32'(s) | (32'(f) << 5), OK);
      rdc(lvd_pkg::ADDR_THRESH_MV, 32'(lvd_pkg::THRESH_MV[s]), OK);
      chk("sel", 32'(s), 32'(sel));
      chk("bg", 32'h1, bg);
    end
    $display("test table done");
    @(posedge clk) idl <= 1'b1;
    wr(A_ST, 32'h3, OK);
    w0 = n_wake;
    // Short dip must not raise the request
    @(posedge clk) mv <= 16'h0BB8;
    repeat (100) @(posedge clk);
    mv <= 16'h0FFF;
    repeat (300) @(posedge clk);
    rdc(A_ST, 32'h2, OK);
    wr(A_ST, 32'h3, OK);
    @(posedge clk) mv <= 16'h0BB8;
    for (n = 0; wake !== 1'b1 && n < 400; n++) @(posedge clk);
    chk("wake delay", 32'h1, 32'(n >= 250 && n <= 262));
    chk("irq masked", 32'h0, irq);
    rdc(A_ST, 32'h1, OK);
    wr(lvd_pkg::ADDR_IRQ_MASK, 32'h1, OK);
    repeat (3) @(posedge clk);
    chk("irq", 32'h1, irq);
    mv <= 16'h0FFF;
    repeat (10) @(posedge clk);
    wr(A_ST, 32'h3, OK);
    repeat (3) @(posedge clk);
    chk("irq", 32'h0, irq);
    $display("test interrupt done");
    // Software pre-set keeps the next rise from waking
    @(posedge clk) idl <= 1'b0;
    wr(lvd_pkg::ADDR_IRQ_SET, 32'h1, OK);
    @(posedge clk) idl <= 1'b1;
    w0 = n_wake;
    mv <= 16'h0BB8;
    repeat (300) @(posedge clk);
    chk("pre-set wake", 32'(w0), 32'(n_wake));
    mv <= 16'h0FFF;
    repeat (10) @(posedge clk);
    wr(A_ST, 32'h3, OK);
    $display("test preset done");
    @(posedge clk) slp <= 1'b1;
    mv <= 16'h0BB8;
    repeat (300) @(posedge clk);
    chk("on sleep", 32'h0, on);
    rdc(A_CT, 32'h1F, OK);
    rdc(A_ST, 32'h0, OK);
    @(posedge clk) slp <= 1'b0;
    repeat (3) @(posedge clk);
    chk("on wake", 32'h1, on);
    wr(A_CT, 32'h0F, OK);
    repeat (10) @(posedge clk);
    chk("on off", 32'h0, on);
    rdc(A_CT, 32'h0F, OK);
    wr(A_CT, 32'h1F, OK);
    repeat (10) @(posedge clk);
    rdc(A_CT, 32'h3F, OK);
    $display("test enable done");
    results();
  end
endmodule : lvd_top_bench
